// ---- design/uregm_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module uregm_top #(
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [2:0] ADDR,
	input  wire logic       RD_STB,
	input  wire logic       WR_STB,
	input  wire logic [7:0] D_IN,
	output var  logic [7:0] D_OUT,
	output var  logic       D_OE,
	input  wire logic       SERIAL_INPUT,
	output var  logic       SERIAL_OUTPUT,
	input  wire logic       CTS_N,
	input  wire logic       DSR_N,
	input  wire logic       RI_N,
	input  wire logic       DCD_N,
	output var  logic       DTR_N,
	output var  logic       RTS_N,
	output var  logic       INTRPT
);

	localparam logic [AW:0] CAP = (AW+1)'(DEPTH);

	// ============================================================
	// Register file
	uregm_pkg::uregm_lfc_type lfc_q;
	logic [3:0]  ien_q;
	logic        qen_q;
	logic [1:0]  trig_q;
	logic [5:0]  hsc_q;
	logic [7:0]  scr_q;
	logic [6:0]  ps_q;
	logic [15:0] div_q;
	logic        rx_clr;
	logic        tx_clr;

	wire divsel  = lfc_q.divsel;
	wire wr_data = WR_STB && ADDR == uregm_pkg::OFS_DATA && !divsel;
	wire rd_data = RD_STB && ADDR == uregm_pkg::OFS_DATA && !divsel;
	wire rd_iid  = RD_STB && ADDR == uregm_pkg::OFS_IID;
	wire rd_lst  = RD_STB && ADDR == uregm_pkg::OFS_LST;
	wire rd_hst  = RD_STB && ADDR == uregm_pkg::OFS_HST;
	wire wr_qc   = WR_STB && ADDR == uregm_pkg::OFS_IID;

	// Changing the enable bit flushes both queues
	assign rx_clr = wr_qc && ((D_IN[uregm_pkg::QC_ENABLE] != qen_q) ||
		(D_IN[uregm_pkg::QC_ENABLE] && D_IN[uregm_pkg::QC_RXCLR]));
	assign tx_clr = wr_qc && ((D_IN[uregm_pkg::QC_ENABLE] != qen_q) ||
		(D_IN[uregm_pkg::QC_ENABLE] && D_IN[uregm_pkg::QC_TXCLR]));

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lfc_q  <= uregm_pkg::uregm_lfc_type'(uregm_pkg::LFC_RST);
			ien_q  <= uregm_pkg::IEN_RST;
			qen_q  <= 1'b0;
			trig_q <= uregm_pkg::TRIG_RST;
			hsc_q  <= uregm_pkg::HSC_RST;
		end else if (WR_STB) begin
			case (ADDR)
				uregm_pkg::OFS_IEN: if (!divsel) ien_q <= D_IN[3:0];
				uregm_pkg::OFS_IID: begin
					qen_q <= D_IN[uregm_pkg::QC_ENABLE];
					// Other fields only take with the enable bit set
					if (D_IN[uregm_pkg::QC_ENABLE]) trig_q <= D_IN[7:6];
				end
				uregm_pkg::OFS_LFC: lfc_q <= uregm_pkg::uregm_lfc_type'(D_IN);
				uregm_pkg::OFS_HSC: hsc_q <= D_IN[5:0];
				default: ;
			endcase
		end
	end

	// Divisors, scratch and prescale survive reset by design
	always_ff @(posedge CLK) begin
		if (WR_STB && divsel && ADDR == uregm_pkg::OFS_DATA) begin
			div_q[7:0] <= D_IN;
		end
		if (WR_STB && divsel && ADDR == uregm_pkg::OFS_IEN) begin
			div_q[15:8] <= D_IN;
		end
		if (WR_STB && ADDR == uregm_pkg::OFS_SCR) begin
			if (divsel) ps_q <= D_IN[6:0];
			else scr_q <= D_IN;
		end
	end

	// ============================================================
	// Prescaler and 16x tick
	logic [5:0]  ps_cnt_q;
	logic [15:0] div_cnt_q;
	logic        tick_q;
	wire  [5:0]  ps_m1 = (ps_q[5:0] == 6'h00) ? 6'h00 : ps_q[5:0] - 6'h01;
	wire         ps_tick = ps_cnt_q == 6'h00;
	wire         baud_wr = WR_STB && divsel &&
		(ADDR == uregm_pkg::OFS_DATA || ADDR == uregm_pkg::OFS_IEN ||
		ADDR == uregm_pkg::OFS_SCR);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ps_cnt_q  <= 6'h00;
			div_cnt_q <= 16'h0000;
			tick_q    <= 1'b0;
		end else if (baud_wr) begin
			// Restart on any rate write: the rate fields are not reset,
			// so the divider only becomes defined once they are written
			ps_cnt_q  <= 6'h00;
			div_cnt_q <= 16'h0000;
			tick_q    <= 1'b0;
		end else begin
			tick_q   <= 1'b0;
			ps_cnt_q <= ps_tick ? ps_m1 : ps_cnt_q - 6'h01;
			if (ps_tick) begin
				if (div_cnt_q <= 16'h0001) begin
					div_cnt_q <= div_q;
					// A zero divisor stops the line clock
					tick_q    <= div_q != 16'h0000;
				end else begin
					div_cnt_q <= div_cnt_q - 16'h0001;
				end
			end
		end
	end

	// ============================================================
	// Character format helpers
	wire [3:0] nbits = 4'h5 + {2'h0, lfc_q.wls};
	wire [7:0] dmask = 8'hff >> (4'h8 - nbits);

	function automatic logic par_of(input logic [7:0] d,
		input uregm_pkg::uregm_lfc_type f);
		par_of = f.stick ? !f.even : (f.even ? ^d : ~^d);
	endfunction

	// ============================================================
	// Receiver
	uregm_pkg::uregm_ser_type rx_st_q;
	logic [3:0] rx_tk_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic       rx_pok_q;
	logic       rx_prev_q;
	logic       rx_done_q;
	logic [7:0] rx_word_q;
	uregm_pkg::uregm_lerr_type rx_err_q;
	wire        rx_in = SERIAL_INPUT;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_st_q   <= uregm_pkg::SER_IDLE;
			rx_tk_q   <= 4'h0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 8'h00;
			rx_pok_q  <= 1'b1;
			rx_prev_q <= 1'b1;
			rx_done_q <= 1'b0;
			rx_word_q <= 8'h00;
			rx_err_q  <= '0;
		end else begin
			rx_done_q <= 1'b0;
			if (tick_q) begin
				rx_prev_q <= rx_in;
				rx_tk_q   <= rx_tk_q + 4'h1;
				case (rx_st_q)
					uregm_pkg::SER_IDLE: if (!rx_in && rx_prev_q) begin
						rx_st_q <= uregm_pkg::SER_START;
						rx_tk_q <= 4'h0;
					end
					uregm_pkg::SER_START: if (rx_tk_q == uregm_pkg::OVS_MID) begin
						// False start: line back high at mid-bit
						rx_st_q  <= rx_in ? uregm_pkg::SER_IDLE : uregm_pkg::SER_DATA;
						rx_tk_q  <= 4'h0;
						rx_bit_q <= 4'h0;
						rx_sh_q  <= 8'h00;
					end
					uregm_pkg::SER_DATA: if (rx_tk_q == uregm_pkg::OVS_LAST) begin
						rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == nbits - 4'h1) begin
							rx_st_q <= lfc_q.pen ? uregm_pkg::SER_PAR : uregm_pkg::SER_STOP;
						end
					end
					uregm_pkg::SER_PAR: if (rx_tk_q == uregm_pkg::OVS_LAST) begin
						rx_pok_q <= rx_in == par_of(rx_sh_q >> (4'h8 - nbits), lfc_q);
						rx_st_q  <= uregm_pkg::SER_STOP;
					end
					uregm_pkg::SER_STOP: if (rx_tk_q == uregm_pkg::OVS_LAST) begin
						rx_word_q   <= rx_sh_q >> (4'h8 - nbits);
						rx_err_q.pe <= lfc_q.pen && !rx_pok_q;
						rx_err_q.fe <= !rx_in;
						rx_err_q.bi <= !rx_in && rx_sh_q == 8'h00;
						rx_done_q   <= 1'b1;
						rx_pok_q    <= 1'b1;
						rx_st_q     <= uregm_pkg::SER_IDLE;
					end
					default: rx_st_q <= uregm_pkg::SER_IDLE;
				endcase
			end
		end
	end

	// ============================================================
	// Receive queue, one deep without FIFO mode
	logic [7:0]    rx_mem [DEPTH];
	logic [AW-1:0] rx_wp_q;
	logic [AW-1:0] rx_rp_q;
	logic [AW:0]   rx_cnt_q;
	wire [AW:0]    rx_cap  = qen_q ? CAP : (AW+1)'(1);
	wire           rx_full = rx_cnt_q >= rx_cap;
	wire           rx_push = rx_done_q && !rx_full;
	wire           rx_pop  = rd_data && rx_cnt_q != '0;

	always_ff @(posedge CLK) begin
		if (rx_push) rx_mem[rx_wp_q] <= rx_word_q;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_wp_q  <= '0;
			rx_rp_q  <= '0;
			rx_cnt_q <= '0;
		end else if (rx_clr) begin
			rx_wp_q  <= '0;
			rx_rp_q  <= '0;
			rx_cnt_q <= '0;
		end else begin
			if (rx_push) rx_wp_q <= rx_wp_q + AW'(1);
			if (rx_pop) rx_rp_q <= rx_rp_q + AW'(1);
			rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
		end
	end

	// Idle timer for the character timeout indication
	logic [9:0] tout_q;
	wire        tout_hit = qen_q && tout_q >= uregm_pkg::TIMEOUT_TICKS;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) tout_q <= '0;
		else if (rx_push || rx_pop || rx_cnt_q == '0) tout_q <= '0;
		else if (tick_q && !tout_hit) tout_q <= tout_q + 10'h001;
	end

	// ============================================================
	// Transmit queue and shifter
	logic [7:0]    tx_mem [DEPTH];
	logic [AW-1:0] tx_wp_q;
	logic [AW-1:0] tx_rp_q;
	logic [AW:0]   tx_cnt_q;
	uregm_pkg::uregm_ser_type tx_st_q;
	logic [4:0] tx_tk_q;
	logic [3:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic       tx_par_q;
	wire [AW:0] tx_cap  = qen_q ? CAP : (AW+1)'(1);
	wire        tx_push = wr_data && tx_cnt_q < tx_cap;
	wire        tx_load = tx_st_q == uregm_pkg::SER_IDLE && tx_cnt_q != '0;
	wire [4:0]  stop_end = !lfc_q.stb ? 5'h0f : (lfc_q.wls == 2'h0 ? 5'h17 : 5'h1f);
	wire [7:0]  tx_next = tx_mem[tx_rp_q] & dmask;

	always_ff @(posedge CLK) begin
		if (tx_push) tx_mem[tx_wp_q] <= D_IN;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_wp_q  <= '0;
			tx_rp_q  <= '0;
			tx_cnt_q <= '0;
		end else if (tx_clr) begin
			tx_wp_q  <= '0;
			tx_rp_q  <= '0;
			tx_cnt_q <= '0;
		end else begin
			if (tx_push) tx_wp_q <= tx_wp_q + AW'(1);
			if (tx_load) tx_rp_q <= tx_rp_q + AW'(1);
			tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_load);
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_st_q  <= uregm_pkg::SER_IDLE;
			tx_tk_q  <= 5'h00;
			tx_bit_q <= 4'h0;
			tx_sh_q  <= 8'h00;
			tx_par_q <= 1'b0;
		end else if (tx_load) begin
			tx_st_q  <= uregm_pkg::SER_START;
			tx_tk_q  <= 5'h00;
			tx_sh_q  <= tx_next;
			tx_par_q <= par_of(tx_next, lfc_q);
		end else if (tick_q) begin
			tx_tk_q <= (tx_tk_q == 5'h0f && tx_st_q != uregm_pkg::SER_STOP) ?
				5'h00 : tx_tk_q + 5'h01;
			case (tx_st_q)
				uregm_pkg::SER_START: if (tx_tk_q == 5'h0f) begin
					tx_st_q  <= uregm_pkg::SER_DATA;
					tx_bit_q <= 4'h0;
				end
				uregm_pkg::SER_DATA: if (tx_tk_q == 5'h0f) begin
					tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
					tx_bit_q <= tx_bit_q + 4'h1;
					if (tx_bit_q == nbits - 4'h1) begin
						tx_st_q <= lfc_q.pen ? uregm_pkg::SER_PAR : uregm_pkg::SER_STOP;
					end
				end
				uregm_pkg::SER_PAR: if (tx_tk_q == 5'h0f) tx_st_q <= uregm_pkg::SER_STOP;
				uregm_pkg::SER_STOP: if (tx_tk_q == stop_end) begin
					tx_st_q <= uregm_pkg::SER_IDLE;
					tx_tk_q <= 5'h00;
				end
				default: ;
			endcase
		end
	end

	logic tx_line;
	always_comb begin
		case (tx_st_q)
			uregm_pkg::SER_START: tx_line = 1'b0;
			uregm_pkg::SER_DATA:  tx_line = tx_sh_q[0];
			uregm_pkg::SER_PAR:   tx_line = tx_par_q;
			default:              tx_line = 1'b1;
		endcase
	end

	// Infrared: a short high pulse marks each zero bit
	wire line_eff = tx_line && !lfc_q.brk;
	wire ir_out   = !line_eff && tx_tk_q < uregm_pkg::IR_PULSE;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) SERIAL_OUTPUT <= 1'b1;
		else SERIAL_OUTPUT <= ps_q[uregm_pkg::PS_IR] ? ir_out : line_eff;
	end

	// ============================================================
	// Line and handshake status, sticky flags: set wins
	uregm_pkg::uregm_lerr_type lerr_q;
	logic [3:0] hdelta_q;
	logic [3:0] hlev_q;
	logic       holding_empty_flag_int_q;
	logic       holding_empty_flag_prev_q;
	wire        holding_empty_flag = tx_cnt_q == '0;
	wire        temt = holding_empty_flag && tx_st_q == uregm_pkg::SER_IDLE;
	wire [3:0]  hlev = {~DCD_N, ~RI_N, ~DSR_N, ~CTS_N};
	wire [3:0]  hchg = {hlev[3] ^ hlev_q[3], !hlev[2] && hlev_q[2],
		hlev[1] ^ hlev_q[1], hlev[0] ^ hlev_q[0]};
	wire [3:0]  lerr_new = {rx_err_q.bi, rx_err_q.fe, rx_err_q.pe, 1'b0} &
		{4{rx_done_q}} | {3'h0, rx_done_q && rx_full};

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			lerr_q   <= '0;
			hdelta_q <= 4'h0;
			hlev_q   <= 4'h0;
		end else begin
			hlev_q   <= hlev;
			lerr_q   <= (rd_lst ? '0 : lerr_q) | lerr_new;
			hdelta_q <= (rd_hst ? 4'h0 : hdelta_q) | hchg;
		end
	end

	// ============================================================
	// Interrupt identity with fixed priority
	logic [4:0] trig_lvl;
	always_comb begin
		case (trig_q)
			2'h0:    trig_lvl = 5'h01;
			2'h1:    trig_lvl = 5'h04;
			2'h2:    trig_lvl = 5'h08;
			default: trig_lvl = 5'h0e;
		endcase
	end

	wire ls_int  = ien_q[uregm_pkg::IEN_LINE] && lerr_q != '0;
	wire rx_lvl  = qen_q ? (5'(rx_cnt_q) >= trig_lvl) : rx_cnt_q != '0;
	wire rx_int  = ien_q[uregm_pkg::IEN_RX] && rx_lvl;
	wire to_int  = ien_q[uregm_pkg::IEN_RX] && tout_hit;
	wire tx_int  = ien_q[uregm_pkg::IEN_TX] && holding_empty_flag_int_q;
	wire hs_int  = ien_q[uregm_pkg::IEN_MODEM] && hdelta_q != 4'h0;
	wire int_any = ls_int || rx_int || to_int || tx_int || hs_int;

	logic [3:0] iid;
	always_comb begin
		if (ls_int) iid = uregm_pkg::IID_LINE;
		else if (rx_int) iid = uregm_pkg::IID_RX;
		else if (to_int) iid = uregm_pkg::IID_TOUT;
		else if (tx_int) iid = uregm_pkg::IID_TX;
		else if (hs_int) iid = uregm_pkg::IID_MODEM;
		else iid = uregm_pkg::IID_NONE;
	end

	// Empty flag fires on each fall to empty; the write or an identity
	// read that reports it clears it, a same-cycle refill re-arms it
	wire holding_empty_flag_set = (holding_empty_flag && !holding_empty_flag_prev_q) ||
		(WR_STB && ADDR == uregm_pkg::OFS_IEN && !divsel &&
		D_IN[uregm_pkg::IEN_TX] && !ien_q[uregm_pkg::IEN_TX] && holding_empty_flag);
	wire holding_empty_flag_clr = wr_data || (rd_iid && iid == uregm_pkg::IID_TX);

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			holding_empty_flag_int_q  <= 1'b0;
			holding_empty_flag_prev_q <= 1'b1;
			INTRPT      <= 1'b0;
		end else begin
			holding_empty_flag_prev_q <= holding_empty_flag;
			holding_empty_flag_int_q  <= holding_empty_flag_set || (holding_empty_flag_int_q && !holding_empty_flag_clr);
			INTRPT      <= int_any;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			DTR_N <= 1'b1;
			RTS_N <= 1'b1;
		end else begin
			DTR_N <= !hsc_q[uregm_pkg::HSC_DTR];
			RTS_N <= !hsc_q[uregm_pkg::HSC_RTS];
		end
	end

	// ============================================================
	// Read data path, answered one cycle after the strobe
	logic [7:0] rdata;
	always_comb begin
		case (ADDR)
			uregm_pkg::OFS_DATA: rdata = divsel ? div_q[7:0] : rx_mem[rx_rp_q];
			uregm_pkg::OFS_IEN:  rdata = divsel ? div_q[15:8] : {4'h0, ien_q};
			uregm_pkg::OFS_IID:  rdata = {{2{qen_q}}, 2'h0, iid};
			uregm_pkg::OFS_LFC:  rdata = lfc_q;
			uregm_pkg::OFS_HSC:  rdata = {2'h0, hsc_q};
			uregm_pkg::OFS_LST:  rdata = {qen_q && lerr_q[3:1] != 3'h0, temt, holding_empty_flag,
				lerr_q, rx_cnt_q != '0};
			uregm_pkg::OFS_HST:  rdata = {hlev, hdelta_q};
			default:             rdata = divsel ? {1'b0, ps_q} : scr_q;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			D_OUT <= 8'h00;
			D_OE  <= 1'b0;
		end else begin
			D_OE <= RD_STB;
			if (RD_STB) D_OUT <= rdata;
		end
	end

	// ============================================================
	// Checks
	iid_compat_bits_a: assert property (@(posedge CLK) disable iff (RST)
		rd_iid && !qen_q && !wr_qc |=> D_OUT[7:6] == 2'h0 && !D_OUT[3])
		else $error("Compatibility identity bits not zero");
	iid_pending_bit_a: assert property (@(posedge CLK) disable iff (RST)
		rd_iid |=> D_OUT[0] == !$past(int_any))
		else $error("Identity pending bit wrong");
	ien_upper_zero_a: assert property (@(posedge CLK) disable iff (RST)
		RD_STB && ADDR == uregm_pkg::OFS_IEN && !divsel |=> D_OUT[7:4] == 4'h0)
		else $error("Enable upper bits not zero");
	rx_depth_a: assert property (@(posedge CLK) disable iff (RST)
		rx_cnt_q <= CAP)
		else $error("Receive queue over depth");
	rx_push_count_a: assert property (@(posedge CLK) disable iff (RST)
		rx_done_q && !rx_full && !rx_pop && !rx_clr |=>
		rx_cnt_q == $past(rx_cnt_q) + 1'b1)
		else $error("Received character not queued");
	rx_read_clears_a: assert property (@(posedge CLK) disable iff (RST)
		!qen_q && rd_data && !rx_done_q && !wr_qc |=> !rx_int ##1
		(!INTRPT || rx_done_q ||
		$past(ls_int || to_int || tx_int || hs_int)))
		else $error("Buffer read left receive interrupt");
	rx_int_raise_a: assert property (@(posedge CLK) disable iff (RST)
		!qen_q && ien_q[0] && !ls_int && rx_cnt_q != '0 |-> iid == uregm_pkg::IID_RX)
		else $error("Receive interrupt not raised");
	tx_idle_load_a: assert property (@(posedge CLK) disable iff (RST)
		tx_st_q != uregm_pkg::SER_IDLE && !tx_clr && !tx_push |=>
		tx_cnt_q == $past(tx_cnt_q))
		else $error("Holding moved while shifter busy");
	holding_empty_flag_write_clr_a: assert property (@(posedge CLK) disable iff (RST)
		wr_data && !holding_empty_flag_set |=> !holding_empty_flag_int_q)
		else $error("Write did not clear empty interrupt");
	tx_start_low_a: assert property (@(posedge CLK) disable iff (RST)
		tx_load && !ps_q[6] |=> ##1 !SERIAL_OUTPUT [*2])
		else $error("Start bit not driven low");

	rx_char_c: cover property (@(posedge CLK) disable iff (RST) rx_push);
	tx_char_c: cover property (@(posedge CLK) disable iff (RST)
		tx_st_q == uregm_pkg::SER_STOP ##1 tx_st_q == uregm_pkg::SER_IDLE);
	timeout_c: cover property (@(posedge CLK) disable iff (RST) to_int);
	ir_mode_c: cover property (@(posedge CLK) disable iff (RST)
		ps_q[6] && tx_st_q == uregm_pkg::SER_DATA);

endmodule

`default_nettype wire

// ---- shared/uregm_pkg.sv ----
`default_nettype none
package uregm_pkg;

	// ============================================================
	// Register offsets
	localparam logic [2:0] OFS_DATA = 3'h0;
	localparam logic [2:0] OFS_IEN  = 3'h1;
	localparam logic [2:0] OFS_IID  = 3'h2;
	localparam logic [2:0] OFS_LFC  = 3'h3;
	localparam logic [2:0] OFS_HSC  = 3'h4;
	localparam logic [2:0] OFS_LST  = 3'h5;
	localparam logic [2:0] OFS_HST  = 3'h6;
	localparam logic [2:0] OFS_SCR  = 3'h7;

	// ============================================================
	// Field positions
	localparam int IEN_RX     = 0;
	localparam int IEN_TX     = 1;
	localparam int IEN_LINE   = 2;
	localparam int IEN_MODEM  = 3;
	localparam int QC_ENABLE  = 0;
	localparam int QC_RXCLR   = 1;
	localparam int QC_TXCLR   = 2;
	localparam int HSC_DTR    = 0;
	localparam int HSC_RTS    = 1;
	localparam int PS_IR      = 6;

	// ============================================================
	// Reset values
	localparam logic [7:0] LFC_RST = 8'h00;
	localparam logic [3:0] IEN_RST = 4'h0;
	localparam logic [5:0] HSC_RST = 6'h00;
	localparam logic [1:0] TRIG_RST = 2'h0;

	// ============================================================
	// Timing and encodings
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] OVS_MID   = 4'h7;
	localparam logic [4:0] IR_PULSE  = 5'h03;
	localparam logic [9:0] TIMEOUT_TICKS = 10'h280;
	localparam logic [3:0] IID_NONE  = 4'h1;
	localparam logic [3:0] IID_LINE  = 4'h6;
	localparam logic [3:0] IID_RX    = 4'h4;
	localparam logic [3:0] IID_TOUT  = 4'hc;
	localparam logic [3:0] IID_TX    = 4'h2;
	localparam logic [3:0] IID_MODEM = 4'h0;

	typedef struct packed {
		logic       divsel;
		logic       brk;
		logic       stick;
		logic       even;
		logic       pen;
		logic       stb;
		logic [1:0] wls;
	} uregm_lfc_type;

	typedef struct packed {
		logic bi;
		logic fe;
		logic pe;
		logic oe;
	} uregm_lerr_type;

	typedef enum logic [2:0] {
		SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
	} uregm_ser_type;

endpackage
`default_nettype wire

// ---- sim/uregm_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Serial peer, 8 data bits, no parity, one stop
module uregm_peer (
	input  wire logic clk,
	input  wire logic line_in,
	output var  logic line_out
);
	int         bit_cyc = 16;
	bit         rx_on = 1'b1;
	logic [7:0] got[$];
	logic [7:0] rb;
	initial line_out = 1'b1;
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out = fr[i];
			repeat (bit_cyc) @(negedge clk);
		end
	endtask
	// Mid-bit sampling tolerates a cycle of start skew
	always begin
		@(negedge clk);
		if (rx_on && line_in === 1'b0) begin
			repeat (bit_cyc / 2) @(negedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cyc) @(negedge clk);
				rb[i] = line_in;
			end
			repeat (bit_cyc) @(negedge clk);
			if (line_in === 1'b1) got.push_back(rb);
		end
	end
endmodule
`default_nettype wire

// ---- sim/uregm_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic       CLK, RST, RD_STB, WR_STB, D_OE, SERIAL_OUTPUT_L, INTRPT;
	logic       CTS_N, DSR_N, RI_N, DCD_N, DTR_N, RTS_N;
	logic [2:0] ADDR;
	logic [7:0] D_IN, D_OUT, v, exp_q[$];
	wire logic  sin_l;
	int         n_errors = 0;
	int         checks = 0;
	int         seed = 96;
	int         n;
	uregm_top dut (
		.CLK(CLK), .RST(RST), .ADDR(ADDR), .RD_STB(RD_STB),
		.WR_STB(WR_STB), .D_IN(D_IN), .D_OUT(D_OUT), .D_OE(D_OE),
		.SERIAL_INPUT(sin_l), .SERIAL_OUTPUT(SERIAL_OUTPUT_L), .CTS_N(CTS_N),
		.DSR_N(DSR_N), .RI_N(RI_N), .DCD_N(DCD_N), .DTR_N(DTR_N),
		.RTS_N(RTS_N), .INTRPT(INTRPT)
	);
	uregm_peer peer (.clk(CLK), .line_in(SERIAL_OUTPUT_L), .line_out(sin_l));
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end
	initial begin
		repeat (60000) @(posedge CLK);
		n_errors++;
		test_done();
	end
	// ============================================================
	// Bus and compare tasks
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge CLK);
		ADDR = a;
		D_IN = d;
		WR_STB = 1'b1;
		@(negedge CLK);
		WR_STB = 1'b0;
	endtask
	task automatic rc(input logic [2:0] a, input logic [7:0] e,
		input string nm);
		@(negedge CLK);
		ADDR = a;
		RD_STB = 1'b1;
		@(negedge CLK);
		RD_STB = 1'b0;
		chk("read answer", 8'h01, {7'h00, D_OE});
		chk(nm, e, D_OUT);
	endtask
	task automatic wait_int(input logic lvl);
		int k;
		for (k = 0; k < 400 && INTRPT !== lvl; k++) @(negedge CLK);
		chk("interrupt", {7'h00, lvl}, {7'h00, INTRPT});
		if (INTRPT !== lvl) test_done();
	endtask
	// Bytes the peer collected against the bench queue, in order
	task automatic tx_cmp(input int m);
		int k;
		for (k = 0; k < 6000 && peer.got.size() < m; k++) @(negedge CLK);
		chk("peer count", 8'(m), 8'(peer.got.size()));
		if (peer.got.size() < m) test_done();
		repeat (m) chk("tx byte", exp_q.pop_front(), peer.got.pop_front());
	endtask
	task automatic test_done;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		RST = 1'b1;
		RD_STB = 1'b0;
		WR_STB = 1'b0;
		ADDR = 3'h0;
		D_IN = 8'h00;
		{CTS_N, DSR_N, RI_N, DCD_N} = 4'hf;
		repeat (8) @(negedge CLK);
		RST = 1'b0;
		rc(uregm_pkg::OFS_IID, 8'h01, "identity idle");
		rc(uregm_pkg::OFS_LST, 8'h60, "line state");
		CTS_N = 1'b0;
		RI_N = 1'b0;
		repeat (4) @(negedge CLK);
		rc(uregm_pkg::OFS_HST, 8'h51, "handshake");
		RI_N = 1'b1;
		repeat (4) @(negedge CLK);
		rc(uregm_pkg::OFS_HST, 8'h14, "ring trailing");
		chk("control idle", 8'h03, {6'h00, DTR_N, RTS_N});
		wr(uregm_pkg::OFS_HSC, 8'h03);
		repeat (2) @(negedge CLK);
		chk("control out", 8'h00, {6'h00, DTR_N, RTS_N});
		wr(uregm_pkg::OFS_LFC, 8'h83);
		wr(uregm_pkg::OFS_DATA, 8'h01);
		wr(uregm_pkg::OFS_IEN, 8'h00);
		wr(uregm_pkg::OFS_SCR, 8'h01);
		rc(uregm_pkg::OFS_DATA, 8'h01, "divisor low");
		wr(uregm_pkg::OFS_LFC, 8'h03);
		wr(uregm_pkg::OFS_IEN, 8'hff);
		rc(uregm_pkg::OFS_IEN, 8'h0f, "enables");
		wr(uregm_pkg::OFS_LFC, 8'h83);
		rc(uregm_pkg::OFS_IEN, 8'h00, "divisor high");
		wr(uregm_pkg::OFS_LFC, 8'h03);
		wr(uregm_pkg::OFS_IEN, 8'h02);
		wait_int(1'b1);
		rc(uregm_pkg::OFS_IID, 8'h02, "tx empty id");
		rc(uregm_pkg::OFS_IID, 8'h01, "id cleared");
		for (int i = 0; i < 2; i++) begin
			v = 8'($random(seed));
			exp_q.push_back(v);
			wr(uregm_pkg::OFS_DATA, v);
			// Let the empty flag rise first, so the write clear stands alone
			repeat (2) @(negedge CLK);
		end
		repeat (2) @(negedge CLK);
		chk("irq after write", 8'h00, {7'h00, INTRPT});
		rc(uregm_pkg::OFS_IID, 8'h01, "holding full");
		wait_int(1'b1);
		tx_cmp(2);
		wr(uregm_pkg::OFS_IEN, 8'h01);
		for (int i = 0; i < 2; i++) begin
			v = 8'($random(seed));
			peer.send(v);
			wait_int(1'b1);
			rc(uregm_pkg::OFS_IID, 8'h04, "rx id");
			rc(uregm_pkg::OFS_DATA, v, "rx byte");
			wait_int(1'b0);
		end
		// One-deep buffer: second character is refused and flags overrun
		peer.send(8'h3c);
		peer.send(8'hc3);
		rc(uregm_pkg::OFS_LST, 8'h63, "overrun");
		rc(uregm_pkg::OFS_DATA, 8'h3c, "kept byte");
		rc(uregm_pkg::OFS_LST, 8'h60, "status cleared");
		// ============================================================
		// Queued mode, 16 bytes each way, receive queue to full depth
		wr(uregm_pkg::OFS_IID, 8'h07);
		rc(uregm_pkg::OFS_IID, 8'hc1, "queued id");
		for (int i = 0; i < 16; i++) begin
			v = 8'($random(seed));
			exp_q.push_back(v);
			peer.send(v);
		end
		rc(uregm_pkg::OFS_IID, 8'hc4, "queued rx id");
		for (int i = 0; i < 16; i++) begin
			rc(uregm_pkg::OFS_DATA, exp_q.pop_front(), "queued rx");
		end
		rc(uregm_pkg::OFS_IID, 8'hc1, "queue drained");
		wr(uregm_pkg::OFS_IEN, 8'h00);
		for (int i = 0; i < 16; i++) begin
			v = 8'($random(seed));
			exp_q.push_back(v);
			wr(uregm_pkg::OFS_DATA, v);
		end
		tx_cmp(16);
		// ============================================================
		// Prescale of two doubles the bit time
		wr(uregm_pkg::OFS_LFC, 8'h83);
		wr(uregm_pkg::OFS_SCR, 8'h02);
		wr(uregm_pkg::OFS_LFC, 8'h03);
		peer.bit_cyc = 32;
		v = 8'($random(seed));
		exp_q.push_back(v);
		wr(uregm_pkg::OFS_DATA, v);
		tx_cmp(1);
		// Pulse output would look like false starts to the peer
		peer.rx_on = 1'b0;
		wr(uregm_pkg::OFS_LFC, 8'h83);
		wr(uregm_pkg::OFS_SCR, 8'h41);
		wr(uregm_pkg::OFS_LFC, 8'h03);
		repeat (4) @(negedge CLK);
		chk("pulse idle", 8'h00, {7'h00, SERIAL_OUTPUT_L});
		wr(uregm_pkg::OFS_DATA, 8'h55);
		n = 0;
		repeat (240) begin
			@(negedge CLK);
			if (SERIAL_OUTPUT_L === 1'b1) n++;
		end
		chk("pulse cycles", 8'h0f, n[7:0]);
		test_done();
	end
endmodule
`default_nettype wire
